/* design/lbd_blink.sv */
// one blink setting: period prescaler and duty compare
module lbd_blink (
  input  wire logic       aclk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [7:0] period_sel,
  input  wire logic [7:0] duty,
  output logic            active
);
  import lbd_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] phase;
    logic       act;
  } lbd_blink_st_t;

  lbd_blink_st_t st_ff;
  lbd_blink_st_t nxt_st;

  // period = (period_sel+1) * STEPS ticks; a smaller new setting takes effect at once
  always_comb begin
    nxt_st = st_ff;
    if (tick) begin
      if (st_ff.cnt >= period_sel) begin
        nxt_st.cnt   = 8'h00;
        nxt_st.phase = st_ff.phase + 8'h01;
      end else begin
        nxt_st.cnt   = st_ff.cnt + 8'h01;
      end
    end
    nxt_st.act = (st_ff.phase < duty);
    if (!rst_n) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign active = st_ff.act;

endmodule

/* design/lbd_pkg.sv */
// shared constants, encodings and helpers of the led blink and dim controller
package lbd_pkg;

  // blink period range: fastest rate and slowest period for each variant
  localparam int unsigned STEPS       = 256;     // duty steps and period steps per setting
  localparam int unsigned DIM_FAST_HZ = 160;
  localparam int unsigned DIM_SLOW_MS = 1600;
  localparam int unsigned BLK_FAST_HZ = 40;
  localparam int unsigned BLK_SLOW_MS = 6400;
  localparam int unsigned MS_PER_S    = 1000;

  // nominal rate of the free-running oscillator input and its allowed drift
  localparam int unsigned OSC_NOM_HZ  = 12_500_000;
  localparam int unsigned OSC_TOL_PCT = 10;

  // register bus layout, byte addresses of 32-bit words
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_INPUT  = 8'h00;
  localparam logic [7:0]  ADDR_PSC0   = 8'h04;
  localparam logic [7:0]  ADDR_PWM0   = 8'h08;
  localparam logic [7:0]  ADDR_PSC1   = 8'h0C;
  localparam logic [7:0]  ADDR_PWM1   = 8'h10;
  localparam logic [7:0]  ADDR_SEL    = 8'h14;
  localparam logic [7:0]  ADDR_STAT   = 8'h18;
  localparam logic [7:0]  ADDR_BLINKS = 8'h1C;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // reset values of the blink settings and output selection
  localparam logic [7:0]  PSC_RST     = 8'hFF;
  localparam logic [7:0]  PWM_RST     = 8'h80;
  localparam logic [31:0] SEL_RST     = 32'h0000_0000;

  // status word bit positions
  localparam int unsigned STAT_B0     = 0;
  localparam int unsigned STAT_B1     = 1;
  localparam int unsigned STAT_PINRST = 2;
  localparam int unsigned STAT_DIMMER = 3;

  // per-output source selection, two bits per output
  typedef enum logic [1:0] {
    SEL_OFF    = 2'b00,
    SEL_ON     = 2'b01,
    SEL_BLINK0 = 2'b10,
    SEL_BLINK1 = 2'b11
  } lbd_sel_t;

  // oscillator edges per duty step: fastest period spread over STEPS steps
  function automatic int unsigned lbd_tick_div(input int unsigned osc_hz, input bit dimmer);
    int unsigned fast;
    int unsigned d;
    fast = dimmer ? DIM_FAST_HZ : BLK_FAST_HZ;
    d    = osc_hz / (fast * STEPS);
    return (d == 0) ? 1 : d;
  endfunction

  // byte-lane merge of a write under its strobes
  function automatic logic [31:0] lbd_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* design/lbd_sync.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
module lbd_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);
  import lbd_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } lbd_sync_st_t;

  lbd_sync_st_t st_ff;
  lbd_sync_st_t nxt_st;

  // first stage feeds only the second stage
  always_comb begin
    nxt_st.meta = d_async;
    nxt_st.held = st_ff.meta;
    if (!aresetn) begin
      nxt_st.meta = RST_VAL;
      nxt_st.held = RST_VAL;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign q_sync = st_ff.held;

endmodule

/* design/lbd_top.sv */
// led blink and dim controller with an axi4-lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
module lbd_top #(
  parameter int unsigned N_LED    = 8,
  parameter bit          DIMMER   = 1'b1,
  parameter int unsigned OSC_HZ   = lbd_pkg::OSC_NOM_HZ,
  parameter int unsigned TICK_DIV = lbd_pkg::lbd_tick_div(OSC_HZ, DIMMER)
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [lbd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [lbd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       osc_clk,
  input  wire logic                       hw_rst_n,
  input  wire logic [N_LED-1:0]           led_i,
  output logic      [N_LED-1:0]           led_o,
  output logic      [N_LED-1:0]           led_oe
);
  import lbd_pkg::*;

  // refuse output counts and dividers that the logic cannot serve
  if (!(N_LED == 2 || N_LED == 4 || N_LED == 8 || N_LED == 16)) begin : g_chk_nled
    $error("N_LED must be 2, 4, 8 or 16");
  end
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_chk_div
    $error("TICK_DIV must lie in 1..65536");
  end
  if (DIM_FAST_HZ * DIM_SLOW_MS != STEPS * MS_PER_S ||
      BLK_FAST_HZ * BLK_SLOW_MS != STEPS * MS_PER_S) begin : g_chk_range
    $error("period range does not match the prescaler width");
  end

  // divider count and selection mask, sized to the registers they meet
  localparam logic [15:0] DIV_M1   = 16'(TICK_DIV - 1);
  localparam logic [31:0] SEL_MASK = (N_LED == 16) ? 32'hFFFF_FFFF
                                                   : ((32'h0000_0001 << (2 * N_LED)) - 32'h0000_0001);
  localparam int unsigned SYNC_W   = N_LED + 2;

  typedef struct packed {
    // write channel
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    // read channel
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    // oscillator tick generation
    logic              osc_prev;
    logic [15:0]       div_cnt;
    logic              tick;
    // blink settings and output selection
    logic [7:0]        psc0;
    logic [7:0]        pwm0;
    logic [7:0]        psc1;
    logic [7:0]        pwm1;
    logic [31:0]       sel;
    logic [N_LED-1:0]  oe;
    logic              pin_rst_seen;
  } lbd_top_st_t;

  lbd_top_st_t st_ff;
  lbd_top_st_t nxt_st;

  logic [SYNC_W-1:0] sync_q;
  logic [N_LED-1:0]  led_s;
  logic              osc_s;
  logic              hw_rst_s;
  logic              blink_rst_n;
  logic              b0_act;
  logic              b1_act;
  logic [31:0]       rd_word;
  logic              rd_err;

  // pins from outside: reset pin idles high so it does not look asserted after aresetn
  lbd_sync #(
    .W       (SYNC_W),
    .RST_VAL ({1'b1, {(SYNC_W - 1){1'b0}}})
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_async ({hw_rst_n, osc_clk, led_i}),
    .q_sync  (sync_q)
  );

  assign led_s    = sync_q[N_LED-1:0];
  assign osc_s    = sync_q[N_LED];
  assign hw_rst_s = sync_q[N_LED+1];

  // the pin reset clears the blink engines as well as the settings
  assign blink_rst_n = aresetn & hw_rst_s;

  // two blink engines, each from its own rate and duty
  lbd_blink u_blink0 (
    .aclk       (aclk),
    .rst_n      (blink_rst_n),
    .tick       (st_ff.tick),
    .period_sel (st_ff.psc0),
    .duty       (st_ff.pwm0),
    .active     (b0_act)
  );

  lbd_blink u_blink1 (
    .aclk       (aclk),
    .rst_n      (blink_rst_n),
    .tick       (st_ff.tick),
    .period_sel (st_ff.psc1),
    .duty       (st_ff.pwm1),
    .active     (b1_act)
  );

  // drive-low decision for one output from its two select bits
  function automatic logic lbd_drive(input logic [1:0] code, input logic a0, input logic a1);
    logic r;
    r = 1'b0;
    unique case (lbd_sel_t'(code))
      SEL_OFF:    r = 1'b0;
      SEL_ON:     r = 1'b1;
      SEL_BLINK0: r = a0;
      SEL_BLINK1: r = a1;
    endcase
    return r;
  endfunction

  // read decode; an unmapped word answers slverr with zero data
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      ADDR_INPUT: begin
        rd_word[N_LED-1:0] = led_s;
      end
      ADDR_PSC0: begin
        rd_word[7:0] = st_ff.psc0;
      end
      ADDR_PWM0: begin
        rd_word[7:0] = st_ff.pwm0;
      end
      ADDR_PSC1: begin
        rd_word[7:0] = st_ff.psc1;
      end
      ADDR_PWM1: begin
        rd_word[7:0] = st_ff.pwm1;
      end
      ADDR_SEL: begin
        rd_word = st_ff.sel;
      end
      ADDR_STAT: begin
        rd_word[STAT_B0]     = b0_act;
        rd_word[STAT_B1]     = b1_act;
        rd_word[STAT_PINRST] = st_ff.pin_rst_seen;
        rd_word[STAT_DIMMER] = DIMMER;
      end
      ADDR_BLINKS: begin
        rd_word = {st_ff.pwm1, st_ff.psc1, st_ff.pwm0, st_ff.psc0};
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // one slot per channel: a new address or data word waits until the response is taken
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;

  // next state of the whole block
  always_comb begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;

    // count rising edges of the oscillator; the bus clock only samples it
    nxt_st.osc_prev = osc_s;
    if (osc_s && !st_ff.osc_prev) begin
      if (st_ff.div_cnt >= DIV_M1) begin
        nxt_st.div_cnt = 16'h0000;
        nxt_st.tick    = 1'b1;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
      end
    end

    // capture address and data in whichever order they arrive
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end

    // response handshakes release their channel
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // perform the write once both halves are held
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      case (st_ff.awaddr)
        ADDR_INPUT: begin
          // input levels are read only; the write is accepted and dropped
        end
        ADDR_PSC0: begin
          if (st_ff.wstrb[0]) nxt_st.psc0 = st_ff.wdata[7:0];
        end
        ADDR_PWM0: begin
          if (st_ff.wstrb[0]) nxt_st.pwm0 = st_ff.wdata[7:0];
        end
        ADDR_PSC1: begin
          if (st_ff.wstrb[0]) nxt_st.psc1 = st_ff.wdata[7:0];
        end
        ADDR_PWM1: begin
          if (st_ff.wstrb[0]) nxt_st.pwm1 = st_ff.wdata[7:0];
        end
        ADDR_SEL: begin
          // bits of absent outputs stay zero
          nxt_st.sel = lbd_merge(st_ff.sel, st_ff.wdata, st_ff.wstrb) & SEL_MASK;
        end
        ADDR_STAT: begin
          if (st_ff.wstrb[0] && st_ff.wdata[STAT_PINRST]) begin
            nxt_st.pin_rst_seen = 1'b0;
          end
        end
        ADDR_BLINKS: begin
          // both settings in one word, two byte lanes each
          merged = lbd_merge({st_ff.pwm1, st_ff.psc1, st_ff.pwm0, st_ff.psc0},
                             st_ff.wdata, st_ff.wstrb);
          nxt_st.psc0 = merged[7:0];
          nxt_st.pwm0 = merged[15:8];
          nxt_st.psc1 = merged[23:16];
          nxt_st.pwm1 = merged[31:24];
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read answers in the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_word;
      nxt_st.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end

    // pin reset returns settings and outputs to defaults; bus state is untouched
    if (!hw_rst_s) begin
      nxt_st.psc0    = PSC_RST;
      nxt_st.pwm0    = PWM_RST;
      nxt_st.psc1    = PSC_RST;
      nxt_st.pwm1    = PWM_RST;
      nxt_st.sel     = SEL_RST;
      nxt_st.div_cnt = 16'h0000;
      // set wins over a clear written in the same cycle
      nxt_st.pin_rst_seen = 1'b1;
    end

    // open-drain drive from the selection; runs with no bus traffic at all
    for (int i = 0; i < N_LED; i++) begin
      nxt_st.oe[i] = lbd_drive(st_ff.sel[2*i +: 2], b0_act, b1_act);
    end
    if (!hw_rst_s) begin
      nxt_st.oe = '0;
    end

    if (!aresetn) begin
      nxt_st              = '0;
      nxt_st.psc0         = PSC_RST;
      nxt_st.pwm0         = PWM_RST;
      nxt_st.psc1         = PSC_RST;
      nxt_st.pwm1         = PWM_RST;
      nxt_st.sel          = SEL_RST;
      nxt_st.bresp        = RESP_OKAY;
      nxt_st.rresp        = RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // outputs straight from flip-flops except led_o, which is tied low; the pad only ever pulls low
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp  = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata  = st_ff.rdata;
  assign s_axi_rresp  = st_ff.rresp;
  assign led_o        = '0;
  assign led_oe       = st_ff.oe;

endmodule

/* testbench/lbd_led_model.sv */
// model of the pins side: free oscillator and pulled-up open-drain lines
module lbd_led_model #(
  parameter int unsigned N_LED = 8
) (
  output logic                  osc_clk,
  input  wire logic [N_LED-1:0] led_oe,
  output logic      [N_LED-1:0] led_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // oscillator runs free, unrelated in phase to the bus clock
  initial osc_clk = 1'b0;
  always #40 osc_clk = ~osc_clk;

  // a released line floats up through its resistor, a driven one reads low
  assign led_i = ~led_oe;
endmodule

/* testbench/lbd_properties.sv */
// concurrent checks on the ports of the led blink and dim controller
module lbd_properties
  import lbd_pkg::*;
#(
  parameter int unsigned N_LED = 8
) (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic [lbd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [lbd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       hw_rst_n,
  input wire logic [N_LED-1:0]           led_o,
  input wire logic [N_LED-1:0]           led_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers and their holding behaviour
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write not answered in two cycles");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  // open drain: the data side never drives high
  a_drain_only: assert property (led_o == '0) else $error("output data not held low");
  // a held reset pin must release every output
  a_pin_release: assert property (!hw_rst_n [*5] |-> led_oe == '0)
    else $error("outputs driven during pin reset");
  a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && led_oe == '0)
    else $error("state not idle after reset");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
  c_pin_reset: cover property ($fell(hw_rst_n));
endmodule

bind lbd_top lbd_properties #(.N_LED(N_LED)) lbd_properties_inst (.*);

/* testbench/testbench.sv */
// self-checking bench of the led blink and dim controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lbd_pkg::*;

  logic aclk, aresetn, osc_clk, hw_rst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] led_i, led_o, led_oe;
  int err_total, checked;
  // when set, bready and rready wait for valid, so the slave must hold its answer
  bit slow_ready;

  lbd_top #(.N_LED(8), .TICK_DIV(1)) lbd_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .osc_clk(osc_clk), .hw_rst_n(hw_rst_n), .led_i(led_i), .led_o(led_o), .led_oe(led_oe));

  lbd_led_model #(.N_LED(8)) lbd_led_model_inst (.osc_clk(osc_clk), .led_oe(led_oe), .led_i(led_i));

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    // an edge between calls, so no signal is driven twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= !slow_ready;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)) begin
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read: address held until taken, rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= !slow_ready;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)) begin
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({what, " resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
    chk(what, exp, d & mask);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the sequence needs about 20k cycles
  initial begin
    #400us;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int hi [4];
    aresetn = 1'b0; hw_rst_n = 1'b1;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);

    // defaults after reset
    chk("oe idle", 32'h0, {24'h0, led_oe});
    rdchk("psc0", ADDR_PSC0, 32'hFF, {24'h0, PSC_RST});
    rdchk("pwm0", ADDR_PWM0, 32'hFF, {24'h0, PWM_RST});
    rdchk("psc1", ADDR_PSC1, 32'hFF, {24'h0, PSC_RST});
    rdchk("pwm1", ADDR_PWM1, 32'hFF, {24'h0, PWM_RST});
    rdchk("sel", ADDR_SEL, 32'hFFFF_FFFF, SEL_RST);
    rdchk("variant", ADDR_STAT, 32'hC, 32'h8);
    $display("test defaults done");

    // both settings in one access, then each read alone
    wr(ADDR_BLINKS, 32'h4001_C000, r);
    chk("blinks resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rdchk("psc0 new", ADDR_PSC0, 32'hFF, 32'h00);
    rdchk("pwm0 new", ADDR_PWM0, 32'hFF, 32'hC0);
    rdchk("psc1 new", ADDR_PSC1, 32'hFF, 32'h01);
    rdchk("pwm1 new", ADDR_PWM1, 32'hFF, 32'h40);
    $display("test settings done");

    // the host holds off its ready: both answers must stand until taken
    slow_ready = 1'b1;
    wr(ADDR_PWM1, 32'h0000_0040, r);
    chk("slow wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rdchk("pwm1 slow", ADDR_PWM1, 32'hFF, 32'h40);
    slow_ready = 1'b0;
    $display("test held answers done");

    // unmapped place and read-only place
    wr(8'h20, 32'hFFFF_FFFF, r);
    chk("bad wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(8'h20, d, r);
    chk("bad rd resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("bad rd data", 32'h0, d);
    wr(ADDR_INPUT, 32'hFFFF_FFFF, r);
    chk("ro wr resp", {30'h0, RESP_OKAY}, {30'h0, r});
    $display("test refusals done");

    // off, on, blink 1, blink 2 on outputs 0..3, the rest off
    wr(ADDR_SEL, 32'h0000_00E4, r);
    rdchk("sel new", ADDR_SEL, 32'hFFFF_FFFF, 32'h0000_00E4);
    repeat (4) @(posedge aclk);
    chk("oe fixed", 32'h2, {30'h0, led_oe[1:0]});
    rdchk("pins", ADDR_INPUT, 32'hF3, 32'hF1);
    // let the new periods settle, then watch one slow period (two fast ones) with the bus quiet
    repeat (9000) @(posedge aclk);
    hi = '{0, 0, 0, 0};
    repeat (8192) begin
      @(posedge aclk);
      // an unknown level spoils the count of its own output instead of passing as off
      for (int i = 0; i < 4; i++) hi[i] += (led_oe[i] === 1'b1) ? 1 : ((led_oe[i] === 1'b0) ? 0 : 100000);
    end
    chk("off stays", 32'd0, hi[0]);
    chk("on stays", 32'd8192, hi[1]);
    chk("duty 1 ok", 32'd1, 32'(hi[2] >= 6112 && hi[2] <= 6176));
    chk("duty 2 ok", 32'd1, 32'(hi[3] >= 2016 && hi[3] <= 2080));
    $display("test blink done");

    // pin reset alone restores defaults and releases outputs
    hw_rst_n <= 1'b0;
    repeat (6) @(posedge aclk);
    hw_rst_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("oe released", 32'h0, {24'h0, led_oe});
    rdchk("psc0 pin", ADDR_PSC0, 32'hFF, {24'h0, PSC_RST});
    rdchk("pwm1 pin", ADDR_PWM1, 32'hFF, {24'h0, PWM_RST});
    rdchk("sel pin", ADDR_SEL, 32'hFFFF_FFFF, SEL_RST);
    rdchk("pin seen", ADDR_STAT, 32'h4, 32'h4);
    wr(ADDR_STAT, 32'h0000_0004, r);
    rdchk("pin cleared", ADDR_STAT, 32'h4, 32'h0);
    $display("test pin reset done");
    end_of_test();
  end
endmodule
